// ### dv/flpa_partner.sv
/*
 * remote partner model: sends configuration words, base pages and link drops.
 * assumes tasks are called right after a rising edge of hclk.
 */
`timescale 1ns/1ps
module flpa_partner (
    input  wire logic   hclk,
    output logic        rx_cfg_valid,
    output logic [15:0] rx_cfg_word,
    output logic        rx_sync_ok,
    output logic        rx_page_rx,
    output logic        rx_link_down
);
    initial begin
        rx_cfg_valid = 1'b0;
        rx_cfg_word  = 16'hFFFF;
        rx_sync_ok   = 1'b1;
        rx_page_rx   = 1'b0;
        rx_link_down = 1'b0;
    end
    // pause and media bits stay zero without enhanced negotiation
    task automatic send_page(input logic [15:0] p, input logic enh, output logic [15:0] w);
        w = enh ? p : p & 16'hFC7F;
        rx_cfg_valid <= 1'b1;
        rx_cfg_word  <= w;
        repeat (3) @(posedge hclk);
        rx_page_rx   <= 1'b1;
        @(posedge hclk);
        rx_page_rx   <= 1'b0;
        repeat (4) @(posedge hclk);
        rx_cfg_valid <= 1'b0;
        rx_cfg_word  <= ~w;
    endtask
    task automatic burst(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        rx_cfg_valid <= 1'b1;
        rx_cfg_word  <= a;
        @(posedge hclk);
        rx_cfg_word  <= b;
        @(posedge hclk);
        rx_cfg_word  <= c;
        @(posedge hclk);
        rx_cfg_valid <= 1'b0;
        rx_cfg_word  <= ~c;
    endtask
    task automatic lose_sync();
        rx_sync_ok <= 1'b0;
        repeat (6) @(posedge hclk);
        rx_sync_ok <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic drop_link();
        rx_link_down <= 1'b1;
        @(posedge hclk);
        rx_link_down <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
endmodule

// ### dv/flpa_top_properties.sv
/*
 * checker for the ability capture top: bus answers and register layouts.
 * assumes it is bound to flpa_top and sees only its ports.
 */
`timescale 1ns/1ps
`include "flpa_params.svh"
module flpa_top_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_cfg_valid,
    input wire logic [15:0] rx_cfg_word,
    input wire logic        rx_sync_ok,
    input wire logic        rx_page_rx,
    input wire logic        rx_link_down,
    input wire logic        partner_able
);
    logic       rd_q;
    logic       wr_q;
    logic [7:0] addr_q;
    logic [1:0] mode_q;
    wire  logic take = hsel && hready && htrans == 2'h2;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
            mode_q <= `FLPA_MODE_RESET;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
            if (wr_q && addr_q == 8'h18) begin
                mode_q <= hwdata[1:0];
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_at(logic [7:0] a);
        rd_q && addr_q == a;
    endsequence
    resp_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    unmapped_zero_a: assert property (rd_q && addr_q[5:4] == 2'h0 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    advert_value_a: assert property (rd_at(8'h10) |-> hrdata == ((mode_q == 2'h3) ? 32'h1 : 32'h0))
        else $error("advertisement word wrong");
    bx_layout_a: assert property (rd_at(8'h14) ##0 mode_q == 2'h1
        |-> (hrdata & ~{16'h0, `FLPA_MASK_1000BX}) == 32'h0) else $error("reserved bit set in 1000bx");
    sys_layout_a: assert property (rd_at(8'h14) ##0 mode_q == 2'h2
        |-> (hrdata & ~{16'h0, `FLPA_MASK_SGMII_SYS}) == 32'h0) else $error("reserved bit set in system");
    med_layout_a: assert property (rd_at(8'h14) ##0 mode_q == 2'h3
        |-> (hrdata & ~{16'h0, `FLPA_MASK_SGMII_MED}) == 32'h0) else $error("reserved bit set in media");
    status_bits_a: assert property (rd_at(8'h1C) |-> hrdata[31:1] == 31'h0) else $error("status high bits set");
    hrdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
    able_sync_a: assert property ($rose(partner_able) |-> $past(rx_sync_ok, 4)) else $error("able without sync");
    sync_loss_clear_a: assert property (!$past(rx_sync_ok, 4) |-> !partner_able)
        else $error("able kept after sync loss");
endmodule

// ### dv/flpa_top_tb_top.sv
/*
 * testbench for the ability capture top: bus master, partner and reference model.
 * assumes the design files and flpa_params.svh are compiled first.
 */
`timescale 1ns/1ps
`include "flpa_params.svh"
module flpa_top_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        partner_able;
    logic        rx_cfg_valid;
    logic [15:0] rx_cfg_word;
    logic        rx_sync_ok;
    logic        rx_page_rx;
    logic        rx_link_down;
    logic [15:0] w;
    logic [15:0] sent[$];
    logic [31:0] rd;
    logic [7:0]  zr[5] = '{8'h10, 8'h14, 8'h1C, 8'h00, 8'h20};
    int          n_errors = 0;
    int          n_checks = 0;
    flpa_top flpa_top_i (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (3'h2),
        .hwdata       (hwdata),
        .hready       (hreadyout),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .rx_cfg_valid (rx_cfg_valid),
        .rx_cfg_word  (rx_cfg_word),
        .rx_sync_ok   (rx_sync_ok),
        .rx_page_rx   (rx_page_rx),
        .rx_link_down (rx_link_down),
        .partner_able (partner_able)
    );
    flpa_partner flpa_partner_i (
        .hclk         (hclk),
        .rx_cfg_valid (rx_cfg_valid),
        .rx_cfg_word  (rx_cfg_word),
        .rx_sync_ok   (rx_sync_ok),
        .rx_page_rx   (rx_page_rx),
        .rx_link_down (rx_link_down)
    );
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    function automatic logic [15:0] exp_abl(input int m, input logic [15:0] p);
        case (m)
            1: return p & `FLPA_MASK_1000BX;
            2: return p & `FLPA_MASK_SGMII_SYS;
            3: return p & `FLPA_MASK_SGMII_MED;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    initial begin
        void'($urandom(32'h8B971DB0));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (zr[i]) rdchk(zr[i], 32'h0);
        for (int m = 1; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                ahb(1'b1, 8'h18, 32'(4 + m + 8 * e));
                flpa_partner_i.send_page(16'($urandom), e[0] || m != 3, w);
                sent.push_back(w);
                rdchk(8'h14, {16'h0, exp_abl(m, sent[$])});
                ahb(1'b1, 8'h14, $urandom);
                rdchk(8'h14, {16'h0, exp_abl(m, sent[$])});
                ahb(1'b1, 8'h10, $urandom);
                rdchk(8'h10, (m == 3) ? 32'h1 : 32'h0);
            end
        end
        flpa_partner_i.drop_link();
        sent.push_back(16'h0000);
        rdchk(8'h14, {16'h0, exp_abl(3, sent[$])});
        ahb(1'b1, 8'h18, 32'h15);
        repeat (3) @(posedge hclk);
        rdchk(8'h1C, 32'h0);
        flpa_partner_i.burst(16'h0A5C, 16'h0A5C, 16'h0C33);
        repeat (10) @(posedge hclk);
        rdchk(8'h1C, 32'h0);
        flpa_partner_i.burst(16'h0C33, 16'h0C33, 16'h0C33);
        for (int i = 0; i < 20 && partner_able !== 1'b1; i++) begin
            @(posedge hclk);
        end
        rdchk(8'h1C, 32'h1);
        chk("partner_able", 32'h1, {31'h0, partner_able});
        flpa_partner_i.lose_sync();
        rdchk(8'h1C, 32'h0);
        chk("partner_able", 32'h0, {31'h0, partner_able});
        ahb(1'b1, 8'h18, 32'h1);
        flpa_partner_i.burst(16'h0C33, 16'h0C33, 16'h0C33);
        repeat (8) @(posedge hclk);
        rdchk(8'h1C, 32'h0);
        stop_test();
    end
endmodule
bind flpa_top flpa_top_properties flpa_top_properties_i (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .rx_cfg_valid (rx_cfg_valid),
    .rx_cfg_word  (rx_cfg_word),
    .rx_sync_ok   (rx_sync_ok),
    .rx_page_rx   (rx_page_rx),
    .rx_link_down (rx_link_down),
    .partner_able (partner_able)
);

// ### logic/flpa_capture.sv
/*
 * holds the last received base page; cleared on link down or reset.
 * assumes single-cycle page and link-down strobes on hclk.
 */
`timescale 1ns/1ps
`include "flpa_params.svh"
module flpa_capture (
    input  wire logic hclk,
    input  wire logic hresetn,
    flpa_rx_if.cap    rx
);
    flpa_pkg::flpa_capture_state_t s_q;
    flpa_pkg::flpa_capture_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (rx.link_down || rx.sw_reset) begin
            s_d.page = `FLPA_ZERO16;
        end else if (rx.page_rx) begin
            s_d.page = rx.cfg_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{page: `FLPA_ZERO16};
        end else begin
            s_q <= s_d;
        end
    end

    assign rx.page = s_q.page;
endmodule

// ### logic/flpa_detect.sv
/*
 * decides whether the partner is negotiation capable from matching
 * configuration code groups.
 * assumes synchronised inputs on hclk.
 */
`timescale 1ns/1ps
`include "flpa_params.svh"
module flpa_detect (
    input  wire logic hclk,
    input  wire logic hresetn,
    flpa_rx_if.det    rx
);
    flpa_pkg::flpa_detect_state_t s_q;
    flpa_pkg::flpa_detect_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (!rx.sync_ok || !rx.aneg_en || rx.sw_reset) begin
            s_d.st       = flpa_pkg::FLPA_ABL_IDLE;
            s_d.seen_cnt = 2'h0;
            s_d.able     = 1'b0;
        end else if (rx.cfg_valid) begin
            case (s_q.st)
                flpa_pkg::FLPA_ABL_IDLE: begin
                    if (rx.cfg_word != `FLPA_ZERO16) begin
                        s_d.word     = rx.cfg_word;
                        s_d.seen_cnt = 2'h1;
                        s_d.st       = flpa_pkg::FLPA_ABL_COUNT;
                    end
                end
                flpa_pkg::FLPA_ABL_COUNT: begin
                    if (rx.cfg_word == `FLPA_ZERO16) begin
                        s_d.st       = flpa_pkg::FLPA_ABL_IDLE;
                        s_d.seen_cnt = 2'h0;
                    end else if (rx.cfg_word != s_q.word) begin
                        s_d.word     = rx.cfg_word;
                        s_d.seen_cnt = 2'h1;
                    end else if (s_q.seen_cnt + 2'h1 == `FLPA_MATCH_NEEDED) begin
                        s_d.seen_cnt = `FLPA_MATCH_NEEDED;
                        s_d.st       = flpa_pkg::FLPA_ABL_ABLE;
                        s_d.able     = 1'b1;
                    end else begin
                        s_d.seen_cnt = s_q.seen_cnt + 2'h1;
                    end
                end
                flpa_pkg::FLPA_ABL_ABLE: begin
                    s_d.able = 1'b1;
                end
                default: begin
                    s_d.st = flpa_pkg::FLPA_ABL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{word: `FLPA_ZERO16, seen_cnt: 2'h0, st: flpa_pkg::FLPA_ABL_IDLE, able: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rx.able = s_q.able;
endmodule

// ### logic/flpa_params.svh
/*
 * constants for the link partner ability capture block: register offsets,
 * field positions, reset values and mode codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef FLPA_PARAMS_SVH
`define FLPA_PARAMS_SVH

`define FLPA_IDX_ADVERT      4'h4
`define FLPA_IDX_PARTNER     4'h5
`define FLPA_IDX_CTRL        4'h6
`define FLPA_IDX_STATUS      4'h7
`define FLPA_ADDR_LSB        2
`define FLPA_ADDR_MSB        5
`define FLPA_ADVERT_MEDIA    16'h0001
`define FLPA_ZERO16          16'h0000
`define FLPA_MODE_1000BX     2'h1
`define FLPA_MODE_SGMII_SYS  2'h2
`define FLPA_MODE_SGMII_MED  2'h3
`define FLPA_MODE_RESET      2'h1
`define FLPA_MASK_1000BX     16'hF1E0
`define FLPA_MASK_SGMII_SYS  16'h4000
`define FLPA_MASK_SGMII_MED  16'hDF80
`define FLPA_MASK_ENHANCED   16'h0380
`define FLPA_MATCH_NEEDED    2'h3
`define FLPA_BIT_ANEG_EN     2
`define FLPA_BIT_ENHANCED    3
`define FLPA_BIT_SWRESET     4
`define FLPA_HTRANS_NONSEQ   1'b1

`endif

// ### logic/flpa_pkg.sv
/*
 * types shared by the link partner ability capture block.
 * assumes flpa_params.svh for numeric constants.
 */
package flpa_pkg;
    typedef enum logic [1:0] {
        FLPA_ABL_IDLE,
        FLPA_ABL_COUNT,
        FLPA_ABL_ABLE
    } flpa_abl_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic [1:0]  seen_cnt;
        flpa_abl_state_t st;
        logic        able;
    } flpa_detect_state_t;

    typedef struct packed {
        logic [15:0] page;
    } flpa_capture_state_t;
endpackage

// ### logic/flpa_rx_if.sv
/*
 * carries received code words and link events between the top and the
 * capture and detect modules.
 * assumes a single clock domain.
 */
`timescale 1ns/1ps
interface flpa_rx_if;
    logic        cfg_valid;
    logic [15:0] cfg_word;
    logic        sync_ok;
    logic        aneg_en;
    logic        page_rx;
    logic        link_down;
    logic        sw_reset;
    logic        able;
    logic [15:0] page;

    modport top (output cfg_valid, output cfg_word, output sync_ok, output aneg_en,
                 output page_rx, output link_down, output sw_reset, input able, input page);
    modport det (input cfg_valid, input cfg_word, input sync_ok, input aneg_en,
                 input sw_reset, output able);
    modport cap (input cfg_word, input page_rx, input link_down, input sw_reset, output page);
endinterface

// ### logic/flpa_top.sv
/*
 * link partner ability capture with an ahb-lite register slave.
 * assumes link-side inputs arrive asynchronously and one ahb master.
 */
`timescale 1ns/1ps
`include "flpa_params.svh"
module flpa_top (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    rx_cfg_valid,
    rx_cfg_word,
    rx_sync_ok,
    rx_page_rx,
    rx_link_down,
    partner_able
);
    input  wire logic        hclk;
    input  wire logic        hresetn;
    input  wire logic        hsel;
    input  wire logic [31:0] haddr;
    input  wire logic [1:0]  htrans;
    input  wire logic        hwrite;
    input  wire logic [2:0]  hsize;
    input  wire logic [31:0] hwdata;
    input  wire logic        hready;
    output logic      [31:0] hrdata;
    output logic             hreadyout;
    output logic             hresp;
    input  wire logic        rx_cfg_valid;
    input  wire logic [15:0] rx_cfg_word;
    input  wire logic        rx_sync_ok;
    input  wire logic        rx_page_rx;
    input  wire logic        rx_link_down;
    output logic             partner_able;

    typedef struct packed {
        logic [1:0]  s1;
        logic [1:0]  s2;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [1:0]  e1;
        logic [1:0]  e2;
        logic        wr_pend;
        logic        rd_pend;
        logic [3:0]  idx;
        logic [1:0]  mode;
        logic        aneg_en;
        logic        enhanced;
        logic        sw_reset;
        logic [31:0] rdata;
        logic        able;
    } flpa_top_state_t;

    flpa_top_state_t s_q;
    flpa_top_state_t s_d;
    flpa_rx_if       rx ();
    logic [15:0]     page_view;
    logic            addr_ph;

    assign addr_ph = hsel && hready && htrans[1] == `FLPA_HTRANS_NONSEQ;

    // layout of the ability register by mode
    always_comb begin
        case (s_q.mode)
            `FLPA_MODE_1000BX: begin
                page_view = rx.page & `FLPA_MASK_1000BX;
            end
            `FLPA_MODE_SGMII_SYS: begin
                page_view = rx.page & `FLPA_MASK_SGMII_SYS;
            end
            `FLPA_MODE_SGMII_MED: begin
                page_view = rx.page & `FLPA_MASK_SGMII_MED;
                if (!s_q.enhanced) begin
                    page_view = page_view & ~`FLPA_MASK_ENHANCED;
                end
            end
            default: begin
                page_view = `FLPA_ZERO16;
            end
        endcase
        // acknowledge shows in the 1000bx, system and media layouts; mode 0 reads zero
    end

    always_comb begin
        s_d          = s_q;
        s_d.s1       = {rx_sync_ok, rx_cfg_valid};
        s_d.s2       = s_q.s1;
        s_d.w1       = rx_cfg_word;
        s_d.w2       = s_q.w1;
        s_d.e1       = {rx_link_down, rx_page_rx};
        s_d.e2       = s_q.e1;
        s_d.sw_reset = 1'b0;
        s_d.able     = rx.able;
        if (addr_ph) begin
            s_d.wr_pend = hwrite;
            s_d.rd_pend = !hwrite;
            s_d.idx     = haddr[`FLPA_ADDR_MSB:`FLPA_ADDR_LSB];
        end else if (hready) begin
            s_d.wr_pend = 1'b0;
            s_d.rd_pend = 1'b0;
        end
        if (s_q.wr_pend && s_q.idx == `FLPA_IDX_CTRL) begin
            s_d.mode     = hwdata[1:0];
            s_d.aneg_en  = hwdata[`FLPA_BIT_ANEG_EN];
            s_d.enhanced = hwdata[`FLPA_BIT_ENHANCED];
            s_d.sw_reset = hwdata[`FLPA_BIT_SWRESET];
        end
        // writes to the advert and ability words fall away
        if (addr_ph && !hwrite) begin
            case (haddr[`FLPA_ADDR_MSB:`FLPA_ADDR_LSB])
                `FLPA_IDX_ADVERT: begin
                    s_d.rdata = {16'h0000, (s_q.mode == `FLPA_MODE_SGMII_MED) ? `FLPA_ADVERT_MEDIA
                                                                                : `FLPA_ZERO16};
                end
                `FLPA_IDX_PARTNER: begin
                    s_d.rdata = {16'h0000, page_view};
                end
                `FLPA_IDX_CTRL: begin
                    s_d.rdata = {27'h0000000, 1'b0, s_q.enhanced, s_q.aneg_en, s_q.mode};
                end
                `FLPA_IDX_STATUS: begin
                    s_d.rdata = {31'h00000000, s_q.able};
                end
                default: begin
                    s_d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q          <= '0;
            s_q.mode     <= `FLPA_MODE_RESET;
            s_q.aneg_en  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx.cfg_valid = s_q.s2[0];
    assign rx.sync_ok   = s_q.s2[1];
    assign rx.cfg_word  = s_q.w2;
    assign rx.page_rx   = s_q.e2[0];
    assign rx.link_down = s_q.e2[1];
    assign rx.aneg_en   = s_q.aneg_en;
    assign rx.sw_reset  = s_q.sw_reset;

    flpa_detect u_detect (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rx      (rx)
    );

    flpa_capture u_capture (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rx      (rx)
    );

    assign hrdata       = s_q.rdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign partner_able = s_q.able;
endmodule
